// ---- logic/csda_consts.svh ----
// Opcode constants, decimal adjust figures and the destination bit position for the compare/skip/decimal execution group.
// Assumes the includer compares against opcode bits [15:9] or [15:8].
`ifndef CSDA_CONSTS_SVH
`define CSDA_CONSTS_SVH

// Seven-bit opcode prefixes (bit 8 is the destination bit)
`define CSDA_OP7_CMPL 7'h09
`define CSDA_OP7_DECR 7'h03
`define CSDA_OP7_DSZ 7'h0b
`define CSDA_OP7_DSNZ 7'h13
`define CSDA_OP7_DADJ 7'h17
// Eight-bit opcode prefixes of the compare instructions
`define CSDA_OP8_CPLT 8'h30
`define CSDA_OP8_CPEQ 8'h31
`define CSDA_OP8_CPGT 8'h32
// Decimal adjust figures
`define CSDA_DA_LOW 8'h06
`define CSDA_DA_HIGH 8'h60
`define CSDA_NIBBLE_MAX 4'h9
// Skip costs this many cycles in total
`define CSDA_SKIP_CYCLES 2
// Destination bit position in the opcode
`define CSDA_DEST_BIT 8

`endif

// ---- logic/csda_exec.sv ----
// Execution unit for complement, compare-skip, decimal adjust and decrement-skip.
// Assumes the pipeline presents one decoded opcode per cycle with file operand already read.
`timescale 1ns/1ps
`include "csda_consts.svh"

// Overview of operation
// - Complement inverts file, sets only zero flag
// - Compare equal skips on match, flags unchanged
// - Compare greater skips on unsigned f above W
// - Compare less skips on unsigned f below W
// - Skip discards fetched instruction, runs NOP
// - Decimal adjust writes W and f, or f
// - Add 06h when low nibble exceeds nine, digit carry
// - Add 60h if high nibble over nine/carry
// - Decimal adjust changes only carry flag
// - Decrement-skip-zero subtracts one, flags untouched
// - Destination zero to W, one to file
// - Zero decrement result skips next instruction
// - Decrement-skip-nonzero skips when result nonzero
module csda_exec
    import csda_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction in execute stage
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    // Operands
    input wire logic [7:0] file_value,
    input wire logic [7:0] wreg_value,
    input wire csda_flags_type flags_in,
    // Results
    output csda_wb_type wb_out,
    output csda_flags_type flags_out,
    output logic flags_we,
    output logic skip_pulse,
    output logic nop_active,
    output logic instr_hit
);

    // Decode fields; a NOP slot suppresses execution
    wire logic [6:0] op7 = instr_word[15:9];
    wire logic [7:0] op8 = instr_word[15:8];
    wire logic dest = instr_word[`CSDA_DEST_BIT];
    wire logic [7:0] faddr = instr_word[7:0];
    csda_state_type state_q;
    csda_state_type state_d;
    wire logic go = instr_valid && (state_q == CSDA_EXEC);
    // Seven-bit prefixes leave bit 8 free for the destination
    wire logic is_cmpl = go && (op7 == `CSDA_OP7_CMPL);
    wire logic is_decr = go && (op7 == `CSDA_OP7_DECR);
    wire logic is_dsz = go && (op7 == `CSDA_OP7_DSZ);
    wire logic is_dsnz = go && (op7 == `CSDA_OP7_DSNZ);
    wire logic is_dadj = go && (op7 == `CSDA_OP7_DADJ);
    // Compares have no destination, so the whole high byte decodes
    wire logic is_cplt = go && (op8 == `CSDA_OP8_CPLT);
    wire logic is_cpeq = go && (op8 == `CSDA_OP8_CPEQ);
    wire logic is_cpgt = go && (op8 == `CSDA_OP8_CPGT);

    // Arithmetic results
    wire logic [7:0] comp_val = ~file_value;
    wire logic [8:0] dec_full = {1'b0, file_value} - 9'h001;
    wire logic [7:0] dec_val = dec_full[7:0];
    wire logic dec_zero = (dec_val == 8'h00);
    // Compare via subtraction only; borrow gives unsigned order, no write-back
    wire logic [8:0] cmp_diff = {1'b0, file_value} - {1'b0, wreg_value};
    wire logic cmp_eq = (cmp_diff[7:0] == 8'h00) && !cmp_diff[8];
    wire logic cmp_lt = cmp_diff[8];
    wire logic cmp_gt = !cmp_lt && !cmp_eq;

    // Decimal adjust in two steps; carry from either step sticks
    wire logic da_low_fix = (wreg_value[3:0] > `CSDA_NIBBLE_MAX) || flags_in.digit_carry_flag;
    wire logic [8:0] da_step1 = {1'b0, wreg_value} + (da_low_fix ? {1'b0, `CSDA_DA_LOW} : 9'h000);
    wire logic da_c1 = da_step1[8] || flags_in.carry_flag;
    wire logic da_high_fix = (da_step1[7:4] > `CSDA_NIBBLE_MAX) || da_c1;
    wire logic [8:0] da_step2 = {1'b0, da_step1[7:0]}
        + (da_high_fix ? {1'b0, `CSDA_DA_HIGH} : 9'h000);
    wire logic da_carry = da_step1[8] || da_step2[8] || flags_in.carry_flag;

    // Skip decision for the skipping instructions
    wire logic skip_now = (is_cpeq && cmp_eq) || (is_cpgt && cmp_gt)
        || (is_cplt && cmp_lt)
        || (is_dsz && dec_zero)
        || (is_dsnz && !dec_zero);

    // Write-back select; destination 0 means W (plus f for decimal adjust)
    wire logic dec_any = is_decr || is_dsz || is_dsnz;
    wire logic [7:0] res = is_cmpl ? comp_val : (is_dadj ? da_step2[7:0] : dec_val);
    wire logic file_we_d = ((is_cmpl || dec_any) && dest) || is_dadj;
    wire logic wreg_we_d = (is_cmpl || dec_any || is_dadj) && !dest;

    // Flag updates: complement touches Z, adjust touches C, decrement-file all four
    csda_flags_type flags_d;
    always_comb begin
        flags_d = flags_in;
        if (is_cmpl) begin
            flags_d.zero_flag = (comp_val == 8'h00);
        end else if (is_dadj) begin
            flags_d.carry_flag = da_carry;
        end else if (is_decr) begin
            flags_d.zero_flag = dec_zero;
            flags_d.carry_flag = !dec_full[8];
            flags_d.digit_carry_flag = (file_value[3:0] != 4'h0);
            flags_d.overflow_flag = (file_value == 8'h80);
        end
    end
    // Skip-type decrements and compares leave flags alone
    wire logic flags_we_d = is_cmpl || is_dadj || is_decr;

    // One NOP cycle follows a taken skip; fetched word is dropped
    always_comb begin
        state_d = CSDA_EXEC;
        if (state_q == CSDA_EXEC && skip_now) begin
            state_d = CSDA_NOP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= CSDA_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered results so data outputs come from flip-flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb_out <= '0;
            flags_out <= '0;
            flags_we <= 1'b0;
            skip_pulse <= 1'b0;
            instr_hit <= 1'b0;
        end else begin
            wb_out <= '{file_we_d, faddr, res, wreg_we_d, res};
            flags_out <= flags_d;
            flags_we <= flags_we_d;
            skip_pulse <= skip_now;
            instr_hit <= is_cmpl || dec_any || is_dadj || is_cpeq || is_cpgt || is_cplt;
        end
    end

    // Handshake-style status is combinational from state
    assign nop_active = (state_q == CSDA_NOP);

    // Checks look one cycle after the instruction, where the registered outputs show it
    // Skip timing: the skipping word itself hits, the word behind it must not
    a_skip_nop: assert property (@(posedge clk_sys) disable iff (sys_rst)
        skip_now |=> nop_active ##1 (!nop_active && !instr_hit && !flags_we
            && !wb_out.file_we && !wb_out.wreg_we))
        else $error("skip did not give exactly one nop cycle");
    a_nop_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        nop_active |=> !instr_hit && !flags_we && !wb_out.file_we && !wb_out.wreg_we)
        else $error("discarded word produced results");
    a_skip_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
        skip_pulse |-> nop_active)
        else $error("skip without a nop slot");

    // Compare group; the subtraction result must never reach a register
    a_cmp_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_cpeq || is_cpgt || is_cplt) |=> !wb_out.file_we && !wb_out.wreg_we && !flags_we)
        else $error("compare wrote a register or flag");
    a_eq_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_cpeq |=> skip_pulse == ($past(file_value) == $past(wreg_value)))
        else $error("compare equal skip wrong");
    a_gt_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_cpgt |=> skip_pulse == ($past(file_value) > $past(wreg_value)))
        else $error("compare greater skip wrong");
    a_lt_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_cplt |=> skip_pulse == ($past(file_value) < $past(wreg_value)))
        else $error("compare less skip wrong");

    // Complement: only the zero flag may move
    a_cmpl_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_cmpl |=> flags_we && wb_out.file_data == ~$past(file_value)
            && flags_out.zero_flag == ($past(file_value) == 8'hff)
            && flags_out.carry_flag == $past(flags_in.carry_flag)
            && flags_out.digit_carry_flag == $past(flags_in.digit_carry_flag)
            && flags_out.overflow_flag == $past(flags_in.overflow_flag))
        else $error("complement value or flags wrong");
    a_cmpl_dest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_cmpl |=> wb_out.file_we == $past(dest) && wb_out.wreg_we == !$past(dest))
        else $error("complement destination wrong");

    // Decrement group; the skip forms keep every flag
    a_dec_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_dsz || is_dsnz) |=> !flags_we && wb_out.file_data == $past(file_value) - 8'h01)
        else $error("decrement value or flags wrong");
    a_dsz_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_dsz |=> !flags_we && skip_pulse == ($past(file_value) == 8'h01))
        else $error("decrement skip zero wrong");
    a_dsnz_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_dsnz |=> skip_pulse == ($past(file_value) != 8'h01))
        else $error("decrement skip nonzero wrong");
    a_dec_dest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_dsz || is_dsnz) |=> wb_out.file_we == $past(dest) && wb_out.wreg_we == !$past(dest))
        else $error("decrement destination wrong");

    // Decimal adjust
    a_dadj_dest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_dadj |=> wb_out.file_we && wb_out.wreg_we == !$past(dest))
        else $error("decimal adjust destination wrong");
    a_dadj_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
        is_dadj |=> flags_we && flags_out.zero_flag == $past(flags_in.zero_flag)
            && flags_out.digit_carry_flag == $past(flags_in.digit_carry_flag)
            && flags_out.overflow_flag == $past(flags_in.overflow_flag))
        else $error("decimal adjust touched another flag");
    a_dadj_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_dadj && wreg_value == 8'h12 && flags_in.digit_carry_flag && !flags_in.carry_flag)
            |=> wb_out.file_data == 8'h18 && !flags_out.carry_flag)
        else $error("decimal adjust low step wrong");
    a_dadj_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_dadj && wreg_value == 8'h9a) |=> wb_out.file_data == 8'h00
            && flags_out.carry_flag)
        else $error("decimal adjust result wrong");

    // Address field travels unchanged to the write-back
    a_file_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (is_cmpl || dec_any || is_dadj) |=> wb_out.file_addr == $past(faddr))
        else $error("write-back address wrong");

    // Scenario covers
    c_eq_skip: cover property (@(posedge clk_sys) is_cpeq && cmp_eq ##1 nop_active);
    c_gt_skip: cover property (@(posedge clk_sys) is_cpgt && cmp_gt ##1 nop_active);
    c_lt_skip: cover property (@(posedge clk_sys) is_cplt && cmp_lt ##1 nop_active);
    c_dsz_skip: cover property (@(posedge clk_sys) is_dsz && dec_zero);
    c_dadj_carry: cover property (@(posedge clk_sys) is_dadj && da_carry);
endmodule

// ---- logic/csda_pkg.sv ----
// Types shared by the compare/skip/decimal execution group.
// Assumes csda_consts.svh is on the include path.
package csda_pkg;
    // Status flags as the core holds them
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } csda_flags_type;

    // Write-back request towards the register file and W
    typedef struct packed {
        logic file_we;
        logic [7:0] file_addr;
        logic [7:0] file_data;
        logic wreg_we;
        logic [7:0] wreg_data;
    } csda_wb_type;

    // Pipeline state: executing or running the substituted NOP
    typedef enum logic {
        CSDA_EXEC = 1'b0,
        CSDA_NOP = 1'b1
    } csda_state_type;
endpackage

// ---- testbench/csda_exec_tb_top.sv ----
// Self-checking bench for the compare, skip, decimal adjust and decrement unit.
// Assumes csda_pkg and csda_exec are compiled first; csda_consts.svh is on the include path.
`timescale 1ns/1ps
`include "csda_consts.svh"

module csda_exec_tb_top
    import csda_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] file_value = 8'h00;
    logic [7:0] wreg_value = 8'h00;
    csda_flags_type flags_in = '0;
    csda_wb_type wb_out;
    csda_flags_type flags_out;
    logic flags_we, skip_pulse, nop_active, instr_hit;
    csda_wb_type nxt_wb = '0, cur_wb = '0;
    csda_flags_type nxt_fo = '0, cur_fo = '0;
    logic nxt_fwe = 1'b0, nxt_skip = 1'b0, nxt_hit = 1'b0, pend_skip = 1'b0, chk_on = 1'b0;
    logic cur_fwe = 1'b0, cur_skip = 1'b0, cur_hit = 1'b0;
    int bad_count = 0, checks_done = 0, seed = 53;
    logic [7:0] ops [8] = '{{`CSDA_OP7_CMPL, 1'b0}, {`CSDA_OP7_DECR, 1'b0},
        {`CSDA_OP7_DSZ, 1'b0}, {`CSDA_OP7_DSNZ, 1'b0}, {`CSDA_OP7_DADJ, 1'b0},
        `CSDA_OP8_CPLT, `CSDA_OP8_CPEQ, `CSDA_OP8_CPGT};

    // 20 MHz core clock
    initial forever #25 clk_sys = ~clk_sys;

    csda_exec uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_value(file_value), .wreg_value(wreg_value),
        .flags_in(flags_in), .wb_out(wb_out), .flags_out(flags_out), .flags_we(flags_we),
        .skip_pulse(skip_pulse), .nop_active(nop_active), .instr_hit(instr_hit));

    // Reference behaviour of one taken instruction
    function automatic void model(input logic [15:0] wd, input logic [7:0] f, w,
            input csda_flags_type fl, output csda_wb_type wb, output csda_flags_type fo,
            output logic fwe, sk, hit);
        logic [8:0] t;
        logic c;
        logic [7:0] r;
        wb = '0;
        fo = fl;
        fwe = 1'b0;
        sk = 1'b0;
        hit = 1'b1;
        wb.file_addr = wd[7:0];
        t = {1'b0, w};
        c = fl.carry_flag;
        r = f - 8'h01;
        case (wd[15:9])
            `CSDA_OP7_CMPL: begin
                r = ~f;
                fwe = 1'b1;
                fo.zero_flag = (r == 8'h00);
            end
            `CSDA_OP7_DECR: begin
                fwe = 1'b1;
                fo.zero_flag = (r == 8'h00);
                fo.carry_flag = (f != 8'h00);
                fo.digit_carry_flag = (f[3:0] != 4'h0);
                fo.overflow_flag = (f == 8'h80);
            end
            `CSDA_OP7_DSZ: sk = (r == 8'h00);
            `CSDA_OP7_DSNZ: sk = (r != 8'h00);
            `CSDA_OP7_DADJ: begin
                if (w[3:0] > 4'h9 || fl.digit_carry_flag) t = t + 9'h006;
                c = c | t[8];
                if (t[7:4] > 4'h9 || c) t = {1'b0, t[7:0]} + 9'h060;
                fo.carry_flag = c | t[8];
                fwe = 1'b1;
                r = t[7:0];
            end
            default: begin
                hit = (wd[15:10] == 6'h0c) && (wd[9:8] != 2'b11);
                sk = hit && ((wd[9:8] == 2'b00 && f < w) || (wd[9:8] == 2'b01 && f == w)
                    || (wd[9:8] == 2'b10 && f > w));
            end
        endcase
        wb.file_data = r;
        wb.wreg_data = r;
        if (wd[15:9] == `CSDA_OP7_DADJ) begin
            wb.file_we = 1'b1;
            wb.wreg_we = !wd[8];
        end else if (hit && wd[15:10] != 6'h0c) begin
            wb.file_we = wd[8];
            wb.wreg_we = !wd[8];
        end
    endfunction

    // Data fields only matter while their write enable is up
    function automatic csda_wb_type mask(input csda_wb_type x);
        mask = x;
        if (x.file_we !== 1'b1) mask.file_addr = '0;
        if (x.file_we !== 1'b1) mask.file_data = '0;
        if (x.wreg_we !== 1'b1) mask.wreg_data = '0;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Present one word; a word behind a taken skip must be ignored
    task automatic drive(input logic v, input logic [15:0] wd, input logic [7:0] f, w,
            input csda_flags_type fl);
        instr_valid <= v;
        instr_word <= wd;
        file_value <= f;
        wreg_value <= w;
        flags_in <= fl;
        if (v && !pend_skip) begin
            model(wd, f, w, fl, nxt_wb, nxt_fo, nxt_fwe, nxt_skip, nxt_hit);
        end else begin
            nxt_wb = '0;
            {nxt_fwe, nxt_skip, nxt_hit} = 3'b000;
        end
        pend_skip = nxt_skip;
        @(posedge clk_sys);
    endtask

    task automatic rand_op(input logic v);
        logic [7:0] hb;
        hb = ops[$unsigned($random(seed)) % 8];
        if (hb[7:4] != 4'h3) hb[0] = 1'($random(seed));
        drive(v, {hb, 8'($random(seed))}, 8'($random(seed)), 8'($random(seed)),
            csda_flags_type'(4'($random(seed))));
    endtask

    // Mid-cycle compare; registered outputs settled long before
    always @(negedge clk_sys) begin
        if (chk_on) begin
            check(32'(mask(wb_out)), 32'(mask(cur_wb)));
            check(32'(flags_we), 32'(cur_fwe));
            if (cur_fwe) check(32'(flags_out), 32'(cur_fo));
            check(32'(skip_pulse), 32'(cur_skip));
            check(32'(nop_active), 32'(cur_skip));
            check(32'(instr_hit), 32'(cur_hit));
        end
        {cur_wb, cur_fo, cur_fwe, cur_skip, cur_hit} = {nxt_wb, nxt_fo, nxt_fwe, nxt_skip, nxt_hit};
    end

    // Hang guard, well beyond the expected few hundred cycles
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // Reset, hand-picked boundaries, then random traffic
    initial begin
        @(posedge clk_sys);
        chk_on = 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        drive(1'b1, 16'h31a5, 8'h3c, 8'h3c, 4'h0);
        drive(1'b1, 16'h1340, 8'hff, 8'h00, 4'h0);
        drive(1'b1, 16'h1340, 8'hff, 8'h00, 4'h0);
        drive(1'b1, 16'h32a0, 8'hff, 8'hfe, 4'h0);
        drive(1'b1, 16'h3007, 8'h00, 8'h01, 4'h0);
        drive(1'b1, 16'h3007, 8'h00, 8'h01, 4'h0);
        drive(1'b1, 16'h3011, 8'h01, 8'h00, 4'h0);
        drive(1'b1, 16'h17aa, 8'h01, 8'h55, 4'h0);
        drive(1'b1, 16'h16bb, 8'h00, 8'h55, 4'h0);
        drive(1'b1, 16'h16bb, 8'h00, 8'h55, 4'hf);
        drive(1'b1, 16'h2601, 8'h01, 8'h00, 4'h0);
        drive(1'b1, 16'h2702, 8'h05, 8'h00, 4'h0);
        drive(1'b1, 16'h2e10, 8'h00, 8'h9a, 4'h0);
        drive(1'b1, 16'h2e10, 8'h00, 8'h9a, 4'h0);
        drive(1'b1, 16'h2f11, 8'h00, 8'h99, 4'h1);
        drive(1'b1, 16'h2e12, 8'h00, 8'h12, 4'h2);
        drive(1'b1, 16'h0680, 8'h80, 8'h00, 4'h0);
        drive(1'b1, 16'h0701, 8'h00, 8'h00, 4'hf);
        drive(1'b1, 16'h0000, 8'h00, 8'h00, 4'h0);
        drive(1'b0, 16'h31a5, 8'h3c, 8'h3c, 4'h0);
        $display("Corner cases done");
        repeat (400) rand_op(($unsigned($random(seed)) % 8) != 0);
        repeat (3) drive(1'b0, 16'h0000, 8'h00, 8'h00, 4'h0);
        $display("Random traffic done");
        tally_and_finish();
    end
endmodule
